// >>> hw/sdw_host.sv
// Purpose: host end: sends mode and code words as 16-bit frames
// Assumes: link clock made here by a divider of clk_in
// Notes: data changes on rising sclk, device samples on falling
`timescale 1ns/10ps
module sdw_host
    import sdw_pkg::*;
#(
    parameter int HALF_DIV = SDW_HALF_DIV // clk_in cycles per sclk half
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [SDW_FRAME_BITS-1:0] word_in, // mode and code, msb first
    input wire logic valid_in,
    output logic ready_out,
    input wire logic abort_in,                    // raise sync mid frame
    output logic busy_out,
    sdw_link_if.host link
);
    // the gap count shares the 8-bit divider, so it bounds HALF_DIV too
    if (HALF_DIV < SDW_MIN_HALF_DIV ||
        HALF_DIV > (255 - SDW_SYNC_HIGH_CYC) / 2) begin : g_bad_div
        $error("sdw_host HALF_DIV breaks link clock limit");
    end
    typedef enum logic [1:0] {
        SDW_H_IDLE = 2'b00,  // sync high, waiting
        SDW_H_SHIFT = 2'b01, // frame in progress
        SDW_H_GAP = 2'b10    // sync high least time
    } sdw_hstate_e;
    typedef struct packed {
        sdw_hstate_e fsm;
        logic [7:0] div;                  // half period counter
        logic [4:0] bits;                 // falls sent
        logic [SDW_FRAME_BITS-1:0] sh;    // output shifter
        logic sync_n;
        logic sclk;
        logic sdata;
        logic busy;                       // frame or gap under way
    } sdw_host_s;
    sdw_host_s st, next_st;
    logic [SDW_FRAME_BITS-1:0] b_data;
    logic b_valid, b_pop, tick;
    // two-entry buffer decouples the word source from the link
    sdw_skid_buf #(.WIDTH(SDW_FRAME_BITS), .DEPTH(2)) u_buf (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .in_data_in(word_in),
        .in_valid_in(valid_in),
        .in_ready_out(ready_out),
        .out_data_out(b_data),
        .out_valid_out(b_valid),
        .out_ready_in(b_pop)
    );
    // frame engine; gap count shares the divider counter
    always_comb begin
        next_st = st;
        b_pop = 1'b0;
        tick = (st.div == 8'(HALF_DIV - 1));
        next_st.div = tick ? 8'h00 : st.div + 8'h01;
        unique case (st.fsm)
            SDW_H_IDLE: begin
                next_st.div = 8'h00;
                if (b_valid) begin
                    // sync falls with the first bit set up
                    b_pop = 1'b1;
                    next_st.sh = b_data;
                    next_st.sdata = b_data[SDW_FRAME_BITS-1];
                    next_st.sync_n = 1'b0;
                    next_st.sclk = 1'b1;
                    next_st.bits = '0;
                    next_st.fsm = SDW_H_SHIFT;
                end
            end
            SDW_H_SHIFT: begin
                if (abort_in) begin
                    // sclk holds its level: a forced rise could cut a
                    // low phase short of the link clock limit
                    next_st.sync_n = 1'b1;
                    next_st.div = 8'h00;
                    next_st.fsm = SDW_H_GAP;
                end else if (tick) begin
                    next_st.sclk = ~st.sclk;
                    if (st.sclk) begin
                        next_st.bits = st.bits + 5'h01;
                    end else if (st.bits == 5'(SDW_FRAME_BITS)) begin
                        // sixteen falls done: raise sync
                        next_st.sync_n = 1'b1;
                        next_st.div = 8'h00;
                        next_st.fsm = SDW_H_GAP;
                    end else begin
                        next_st.sh = {st.sh[SDW_FRAME_BITS-2:0], 1'b0};
                        next_st.sdata = st.sh[SDW_FRAME_BITS-2];
                    end
                end
            end
            SDW_H_GAP: begin
                if (st.div == 8'(SDW_SYNC_HIGH_CYC + 2 * HALF_DIV)) begin
                    next_st.fsm = SDW_H_IDLE;
                    next_st.sclk = 1'b1;
                end else begin
                    next_st.div = st.div + 8'h01;
                end
            end
            default: next_st.fsm = SDW_H_IDLE;
        endcase
        // busy leaves a flop so the port needs no gate behind it
        next_st.busy = (next_st.fsm != SDW_H_IDLE);
    end
    // state register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st <= '0;
            st.sync_n <= 1'b1;
            st.sclk <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
    assign busy_out = st.busy;
    assign link.sync_n = st.sync_n;
    assign link.sclk = st.sclk;
    assign link.sdata = st.sdata;
endmodule : sdw_host

// >>> hw/sdw_pkg.sv
// Purpose: shared constants and types for the serial converter write link
// Assumes: one system clock at 100 MHz, link clock sampled by it
// Notes: frame is two mode bits then fourteen code bits, msb first
package sdw_pkg;
    localparam int SDW_FRAME_BITS = 16;   // shifter width
    localparam int SDW_CODE_BITS = 14;    // converter code width
    localparam int SDW_MODE_BITS = 2;     // operating mode width
    localparam int SDW_MODE_HI_POS = 15;  // mode_bit_hi position
    localparam int SDW_MODE_LO_POS = 14;  // mode_bit_lo position
    localparam int SDW_CLK_MHZ = 100;     // system clock rate
    localparam int SDW_SYNC_HIGH_NS = 33; // least frame sync high time
    // least time rounds up to whole cycles
    localparam int SDW_SYNC_HIGH_CYC =
        (SDW_SYNC_HIGH_NS * SDW_CLK_MHZ + 999) / 1000;
    localparam int SDW_MAX_SCLK_MHZ = 30; // fastest allowed link clock
    // least half period of the host divider so sclk stays under the limit
    localparam int SDW_MIN_HALF_DIV =
        (SDW_CLK_MHZ + 2 * SDW_MAX_SCLK_MHZ - 1) / (2 * SDW_MAX_SCLK_MHZ);
    localparam int SDW_HALF_DIV = 8;      // default half period, 160 ns sclk
    localparam logic [15:0] SDW_CODE_RST = 16'h0000; // power-on code
    typedef enum logic [1:0] {
        SDW_MODE_NORMAL = 2'b00,  // normal operation
        SDW_MODE_PD_1K = 2'b01,   // power-down, 1k pull to ground
        SDW_MODE_PD_100K = 2'b10, // power-down, 100k pull to ground
        SDW_MODE_PD_TRI = 2'b11   // power-down, three-state
    } sdw_mode_e;
endpackage : sdw_pkg

// >>> hw/sdw_link_if.sv
// Purpose: three-wire link between host and converter ends
// Assumes: host drives every wire, device only listens
// Notes: no clocking block, the bench joins both modports
`timescale 1ns/10ps
interface sdw_link_if;
    logic sync_n;  // frame sync, active low
    logic sclk;    // serial clock
    logic sdata;   // serial data
    modport host (output sync_n, output sclk, output sdata);
    modport device (input sync_n, input sclk, input sdata);
endinterface : sdw_link_if

// >>> hw/sdw_skid_buf.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: ready in comes straight from a flop, so a stall loses no word
`timescale 1ns/10ps
module sdw_skid_buf
    import sdw_pkg::*;
#(
    parameter int WIDTH = 16, // word width
    parameter int DEPTH = 2   // entries
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [WIDTH-1:0] in_data_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    output logic [WIDTH-1:0] out_data_out,
    output logic out_valid_out,
    input wire logic out_ready_in
);
    // pointers are one bit wide, so only two entries can be served
    if (DEPTH != 2 || WIDTH < 1) begin : g_bad_size
        $error("sdw_skid_buf needs depth 2");
    end
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem; // storage
        logic wr;                   // write pointer
        logic rd;                   // read pointer
        logic [1:0] cnt;            // fill level
        logic rdy;                  // room for a word, registered
    } sdw_buf_s;
    sdw_buf_s st, next_st;
    logic push, pop;
    // handshake on each side
    always_comb begin
        push = in_valid_in && (st.cnt != 2'h2);
        pop = (st.cnt != 2'h0) && out_ready_in;
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data_in;
            next_st.wr = ~st.wr;
        end
        if (pop) begin
            next_st.rd = ~st.rd;
        end
        next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
        next_st.rdy = (next_st.cnt != 2'h2);
    end
    // state register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st <= '0;
            st.rdy <= 1'b1;
        end else begin
            st <= next_st;
        end
    end
    assign in_ready_out = st.rdy;
    assign out_valid_out = (st.cnt != 2'h0);
    assign out_data_out = st.mem[st.rd];
endmodule : sdw_skid_buf

// >>> hw/sdw_dev.sv
// Purpose: converter end: receives frames and holds mode and code
// Assumes: link wires come from another domain, two flops each
// Notes: the link clock is sampled, so it must run well below clk_in/2
`timescale 1ns/10ps
module sdw_dev
    import sdw_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    sdw_link_if.device link,
    output logic [SDW_CODE_BITS-1:0] code_out,   // converter code
    output sdw_mode_e mode_out,                  // operating mode
    output logic power_down_out,                 // any power-down mode
    output logic update_out,                     // pulse on frame applied
    output logic abort_out                       // pulse on aborted frame
);
    typedef struct packed {
        logic [1:0] sync_m;                      // sync synchroniser
        logic [1:0] sclk_m;                      // clock synchroniser
        logic [1:0] data_m;                      // data synchroniser
        logic sync_d;                            // last settled sync
        logic sclk_d;                            // last settled clock
        logic armed;                             // frame may take bits
        logic [4:0] cnt;                         // bits taken
        logic [SDW_FRAME_BITS-1:0] shift;        // input shifter
        logic [SDW_CODE_BITS-1:0] code;          // code register
        sdw_mode_e mode;                         // mode register
        logic pd;                                // power-down flag
        logic upd;                               // update pulse
        logic abt;                               // abort pulse
    } sdw_dev_s;
    sdw_dev_s st, next_st;
    logic sync_n, sclk_fall, sync_fall, sync_rise;
    logic [SDW_FRAME_BITS-1:0] word;
    // edges are taken only from the second synchroniser stage
    always_comb begin
        sync_n = st.sync_m[1];
        sclk_fall = st.sclk_d && !st.sclk_m[1];
        sync_fall = st.sync_d && !sync_n;
        sync_rise = !st.sync_d && sync_n;
        word = {st.shift[SDW_FRAME_BITS-2:0], st.data_m[1]};
    end
    // frame receiver
    always_comb begin
        next_st = st;
        next_st.sync_m = {st.sync_m[0], link.sync_n};
        next_st.sclk_m = {st.sclk_m[0], link.sclk};
        next_st.data_m = {st.data_m[0], link.sdata};
        next_st.sync_d = sync_n;
        next_st.sclk_d = st.sclk_m[1];
        next_st.upd = 1'b0;
        next_st.abt = 1'b0;
        if (sync_n) begin
            // idle: counter and shifter cleared
            next_st.cnt = '0;
            next_st.shift = '0;
            next_st.armed = 1'b0;
            if (sync_rise && st.armed) begin
                next_st.abt = 1'b1;
            end
        end else if (sync_fall) begin
            next_st.armed = 1'b1;
        end else if (st.armed && sclk_fall) begin
            // shift in msb first
            next_st.shift = word;
            next_st.cnt = st.cnt + 5'h01;
            if (st.cnt == 5'(SDW_FRAME_BITS - 1)) begin
                // frame complete: apply at once, then wait for sync
                next_st.armed = 1'b0;
                next_st.mode = sdw_mode_e'({word[SDW_MODE_HI_POS],
                                            word[SDW_MODE_LO_POS]});
                next_st.code = word[SDW_CODE_BITS-1:0];
                next_st.pd = ({word[SDW_MODE_HI_POS],
                               word[SDW_MODE_LO_POS]} != 2'b00);
                next_st.upd = 1'b1;
            end
        end
    end
    // state register; the sync synchroniser and the last settled sync start idle high, clock and data start low
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st <= '0;
            st.sync_m <= 2'h3;
            st.sync_d <= 1'b1;
            st.code <= SDW_CODE_RST[SDW_CODE_BITS-1:0];
            st.mode <= SDW_MODE_NORMAL;
        end else begin
            st <= next_st;
        end
    end
    assign code_out = st.code;
    assign mode_out = st.mode;
    assign power_down_out = st.pd;
    assign update_out = st.upd;
    assign abort_out = st.abt;
endmodule : sdw_dev

// >>> verification/sdw_link_checker.sv
// Purpose: watches the first link and the converter outputs behind it
// Assumes: one clock domain, synchronous active-high reset
// Notes: counts link clock falls itself to judge each update
`timescale 1ns/10ps
module sdw_link_checker
    import sdw_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic sync_n,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic [SDW_CODE_BITS-1:0] code_out,
    input wire sdw_mode_e mode_out,
    input wire logic power_down_out,
    input wire logic update_out,
    input wire logic abort_out
);
    // helper state: last pins, falls in this frame, bits gathered
    typedef struct packed {
        logic sync_q;
        logic sclk_q;
        logic [5:0] falls;
        logic [15:0] shadow;
    } sdw_chk_s;
    sdw_chk_s st; // registered copy
    sdw_chk_s next_st; // next value
    // counting stops at sixteen so trailing clocks add nothing
    always_comb begin
        next_st = st;
        next_st.sync_q = sync_n;
        next_st.sclk_q = sclk;
        if (st.sync_q && !sync_n) begin
            next_st.falls = 6'h00;
            next_st.shadow = 16'h0000;
        end else if (!sync_n && st.sclk_q && !sclk && st.falls < 6'h10) begin
            next_st.falls = st.falls + 6'h01;
            next_st.shadow = {st.shadow[14:0], sdata};
        end
    end
    // reset leaves the link idle with sync and clock high
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            st <= '{1'b1, 1'b1, 6'h00, 16'h0000};
        end else begin
            st <= next_st;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // last data fall of a frame as seen at the pins
    sequence s_last_fall;
        !sync_n && st.sclk_q && !sclk && st.falls == 6'h0f;
    endsequence
    // sync rises while the frame is still short
    sequence s_early_rise;
        $rose(sync_n) && st.falls < 6'h10;
    endsequence
    a_update_timely: assert property (s_last_fall |-> ##[1:8] update_out)
        else $error("no update after the last link clock fall");
    a_update_count: assert property (update_out |-> st.falls == 6'h10)
        else $error("update without sixteen link clock falls");
    a_update_word: assert property (
        update_out |-> {mode_out, code_out} == st.shadow)
        else $error("applied word differs from the bits shifted in");
    a_abort_timely: assert property (s_early_rise |-> ##[1:8] abort_out)
        else $error("short frame not flagged as aborted");
    a_output_quiet: assert property (
        $changed(code_out) || $changed(mode_out) |-> update_out)
        else $error("code or mode changed without an update");
    a_pd_flag: assert property (
        power_down_out == (mode_out != SDW_MODE_NORMAL))
        else $error("power down flag disagrees with mode");
    a_sync_gap: assert property ($rose(sync_n) |-> sync_n[*4])
        else $error("frame sync high time too short");
    a_sclk_low_min: assert property ($fell(sclk) |-> !sclk[*2])
        else $error("link clock low phase too short");
endmodule : sdw_link_checker

// >>> verification/tb_serial_dac_write_interface.sv
// Purpose: host words on one link, hand-made frames on a second one
// Assumes: host divider 8 gives a 160 ns link clock
// Notes: second link breaks the rules on purpose, checker sits on first
`timescale 1ns/10ps
module tb_serial_dac_write_interface;
    import sdw_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [15:0] word_in = 16'h0000;
    logic valid_in = 1'b0;
    logic abort_in = 1'b0;
    logic ready_out, busy_out, update_out, abort_out, power_down_out;
    logic [SDW_CODE_BITS-1:0] code_out, code_b;
    sdw_mode_e mode_out, mode_b;
    logic pd_b, upd_b, abt_b; // second converter outputs
    logic [15:0] exp_q[$], exp_b[$]; // notes of expected words
    logic [15:0] last, last_b; // last word taken off each queue
    logic [31:0] r;
    int failures = 0;
    int cmp_count = 0;
    int aborts = 0; // abort pulses on both links
    int seed = 32'h65a2;
    int n;
    sdw_link_if lk(); // host to converter
    sdw_link_if lb(); // bench to second converter
    sdw_host #(.HALF_DIV(8)) i_sdw_host (.clk_in, .sys_rst_in, .word_in,
        .valid_in, .ready_out, .abort_in, .busy_out, .link(lk.host));
    sdw_dev i_sdw_dev (.clk_in, .sys_rst_in, .link(lk.device), .code_out,
        .mode_out, .power_down_out, .update_out, .abort_out);
    sdw_dev i_sdw_dev_2 (.clk_in, .sys_rst_in, .link(lb.device),
        .code_out(code_b), .mode_out(mode_b), .power_down_out(pd_b),
        .update_out(upd_b), .abort_out(abt_b));
    sdw_link_checker i_sdw_link_checker (.clk_in, .sys_rst_in,
        .sync_n(lk.sync_n), .sclk(lk.sclk), .sdata(lk.sdata), .code_out,
        .mode_out, .power_down_out, .update_out, .abort_out);
    // free-running system clock
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    // every wait counts here so a hang ends the run
    task automatic lim(inout int k);
        k++;
        if (k > 3000) begin
            failures++;
            $display("[ERR] %0t wait ran out", $time);
            complete_run();
        end
    endtask : lim
    // offer a word; note it unless it is meant to be cut short
    task automatic send(input logic [15:0] w, input bit keep);
        int k;
        k = 0;
        @(negedge clk_in);
        word_in = w;
        valid_in = 1'b1;
        while (ready_out !== 1'b1) begin
            @(negedge clk_in);
            lim(k);
        end
        if (keep) begin
            exp_q.push_back(w);
        end
        @(negedge clk_in);
        valid_in = 1'b0;
    endtask : send
    task automatic idle();
        int k;
        k = 0;
        while (busy_out !== 1'b0 || exp_q.size() != 0) begin
            @(negedge clk_in);
            lim(k);
        end
    endtask : idle
    // bit-bang the second link; fr low keeps sync high on purpose
    task automatic wire_b(input logic [15:0] w, input int nb, input bit fr);
        lb.sync_n = ~fr;
        repeat (8) @(negedge clk_in);
        for (int i = 0; i < nb; i++) begin
            lb.sdata = w[15 - (i % 16)] ^ (i > 15);
            lb.sclk = 1'b1;
            repeat (8) @(negedge clk_in);
            lb.sclk = 1'b0;
            repeat (8) @(negedge clk_in);
        end
        lb.sync_n = 1'b1;
        lb.sclk = 1'b1;
        lb.sdata = ~lb.sdata; // no stale bit once deselected
        repeat (8) @(negedge clk_in);
    endtask : wire_b
    // each update pulse takes the oldest note of its link
    always @(negedge clk_in) begin
        if (update_out === 1'b1) begin
            last = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
            chk({mode_out, code_out}, last);
            chk({15'h0, power_down_out}, {15'h0, |last[15:14]});
        end
        if (upd_b === 1'b1) begin
            last_b = (exp_b.size() > 0) ? exp_b.pop_front() : 16'hxxxx;
            chk({mode_b, code_b}, last_b);
        end
        aborts += (abort_out === 1'b1) + (abt_b === 1'b1);
    end
    initial begin
        lb.sync_n = 1'b1;
        lb.sclk = 1'b1;
        lb.sdata = 1'b0;
        repeat (10) @(negedge clk_in);
        sys_rst_in = 1'b0;
        chk({mode_out, code_out}, 16'h0000);
        r = $random(seed);
        for (int m = 0; m < 4; m++) begin
            send({m[1:0], r[13:0]}, 1'b1);
        end
        send(16'h3fff, 1'b1);
        send(16'h0000, 1'b1);
        repeat (4) begin
            r = $random(seed);
            send({2'b00, r[13:0]}, 1'b1);
        end
        idle();
        $display("modes and burst done");
        send({2'b11, ~last[13:0]}, 1'b0);
        n = 0;
        while (lk.sync_n !== 1'b0) begin
            @(negedge clk_in);
            lim(n);
        end
        repeat (40) @(negedge clk_in);
        abort_in = 1'b1;
        while (lk.sync_n !== 1'b1) begin
            @(negedge clk_in);
            lim(n);
        end
        abort_in = 1'b0;
        repeat (20) @(negedge clk_in);
        chk({mode_out, code_out}, last);
        $display("host abort done");
        wire_b(16'h5a5a, 16, 1'b0);
        exp_b.push_back(16'h9c3e);
        wire_b(16'h9c3e, 32, 1'b1);
        wire_b(16'h4123, 7, 1'b1);
        // park sync low, raise it just before the next frame; the empty
        // frame that parking opens ends as one more abort
        lb.sync_n = 1'b0;
        repeat (30) @(negedge clk_in);
        lb.sync_n = 1'b1;
        repeat (4) @(negedge clk_in);
        exp_b.push_back(16'h0001);
        wire_b(16'h0001, 16, 1'b1);
        repeat (20) @(negedge clk_in);
        chk(16'(exp_q.size() + exp_b.size()), 16'h0000);
        chk(16'(aborts), 16'h0003);
        $display("second link done");
        complete_run();
    end
endmodule : tb_serial_dac_write_interface
